//--- core/eeprom_array.sv
`timescale 1ns/1ps
module eeprom_array
	import eeprom_pkg::*;
(
	input  wire logic                       clk_in,
	input  wire logic                       ce_in,
	input  wire logic                       wr_en_in,
	input  wire logic [eeprom_pkg::ADDR_W-1:0] wr_addr_in,
	input  wire logic [7:0]                 wr_data_in,
	input  wire logic [eeprom_pkg::ADDR_W-1:0] rd_addr_in,
	output logic      [7:0]                 rd_data_out
);
	import eeprom_pkg::*;

	typedef struct packed {
		logic [ARRAY_WORDS-1:0][7:0] cells;
		logic [7:0]                  rd;
	} arr_t;

	arr_t st;
	arr_t nx;

	// contents are nonvolatile in intent, so no reset touches them
	always_comb begin
		nx = st;
		if (wr_en_in) begin
			nx.cells[wr_addr_in] = wr_data_in;
		end
		nx.rd = st.cells[rd_addr_in];
	end

	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			st <= nx;
		end
	end

	assign rd_data_out = st.rd;

endmodule // eeprom_array

//--- core/eeprom_slave.sv
`timescale 1ns/1ps
module eeprom_slave
	import eeprom_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = eeprom_pkg::TWR_CYCLES
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       ce_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic [2:0] chip_select_straps_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	output logic            busy_out
);
	import eeprom_pkg::*;

	// ******************************************************
	// state
	// ******************************************************
	typedef struct packed {
		logic                      scl_s1;
		logic                      scl_s2;
		logic                      scl_p;
		logic                      sda_s1;
		logic                      sda_s2;
		logic                      sda_p;
		logic [2:0]                cs_s1;
		logic [2:0]                cs_s2;
		fsm_t                      state;
		fsm_t                      after;
		logic [2:0]                cnt;
		logic [7:0]                shift;
		logic [7:0]                tx;
		logic                      is_read;
		logic [7:0]                ptr;
		logic                      sda_oe;
		logic [PAGE_BYTES-1:0][7:0] page;
		logic [PAGE_BYTES-1:0]     valid;
		logic                      busy;
		logic                      commit;
		logic [PAGE_W-1:0]         cidx;
		logic [TIMER_W-1:0]        timer;
	} slave_t;

	slave_t st;
	slave_t nx;

	logic              scl_rise;
	logic              scl_fall;
	logic              start_det;
	logic              stop_det;
	logic              addr_match;
	logic [7:0]        rx_byte;
	logic [7:0]        mem_rd;
	logic              mem_we;
	logic [ADDR_W-1:0] mem_wa;

	// ******************************************************
	// bus events, taken from the second sync stage only
	// ******************************************************
	assign scl_rise  = st.scl_s2 & ~st.scl_p;
	assign scl_fall  = ~st.scl_s2 & st.scl_p;
	assign start_det = st.scl_s2 & st.scl_p & ~st.sda_s2 & st.sda_p;
	assign stop_det  = st.scl_s2 & st.scl_p & st.sda_s2 & ~st.sda_p;
	assign rx_byte   = {st.shift[6:0], st.sda_s2};
	assign addr_match = (rx_byte[7:4] == DEVICE_CODE)
		&& (rx_byte[3:1] == st.cs_s2)
		&& !st.busy;

	// ******************************************************
	// array and commit port
	// ******************************************************
	assign mem_we = st.busy & st.commit & st.valid[st.cidx];
	assign mem_wa = {st.ptr[ADDR_W-1:PAGE_W], st.cidx};

	eeprom_array u_array (
		.clk_in      (clk_in),
		.ce_in       (ce_in),
		.wr_en_in    (mem_we),
		.wr_addr_in  (mem_wa),
		.wr_data_in  (st.page[st.cidx]),
		.rd_addr_in  (st.ptr[ADDR_W-1:0]),
		.rd_data_out (mem_rd)
	);

	// ******************************************************
	// next state
	// ******************************************************
	always_comb begin
		nx = st;
		nx.scl_s1 = scl_in;
		nx.scl_s2 = st.scl_s1;
		nx.scl_p  = st.scl_s2;
		nx.sda_s1 = sda_in;
		nx.sda_s2 = st.sda_s1;
		nx.sda_p  = st.sda_s2;
		nx.cs_s1  = chip_select_straps_in;
		nx.cs_s2  = st.cs_s1;

		// self-timed write: copy the page into the array, then wait
		if (st.busy) begin
			if (st.commit) begin
				nx.cidx = st.cidx + 3'h1;
				if (st.cidx == BIT_LAST) begin
					nx.commit = 1'b0;
					nx.valid  = '0;
					nx.timer  = TIMER_W'(WRITE_CYCLES);
				end
			end else if (st.timer <= TIMER_W'(1)) begin
				nx.busy = 1'b0;
			end else begin
				nx.timer = st.timer - TIMER_W'(1);
			end
		end

		// a repeated START drops uncommitted bytes but keeps the pointer
		if (start_det) begin
			nx.state  = S_ADDR;
			nx.cnt    = BIT_FIRST;
			nx.sda_oe = 1'b0;
			if (!st.busy) begin
				nx.valid = '0;
			end
		end else if (stop_det) begin
			nx.state  = S_IDLE;
			nx.sda_oe = 1'b0;
			if ((|st.valid) && !st.busy) begin
				nx.busy   = 1'b1;
				nx.commit = 1'b1;
				nx.cidx   = '0;
			end
		end else begin
			case (st.state)
				S_ADDR, S_WORD, S_WDATA: begin
					if (scl_rise) begin
						nx.shift = rx_byte;
						nx.cnt   = st.cnt + 3'h1;
						if (st.cnt == BIT_LAST) begin
							nx.state = S_ACK;
							case (st.state)
								S_ADDR: begin
									nx.is_read = rx_byte[0];
									nx.after   = rx_byte[0] ? S_RDATA : S_WORD;
									if (!addr_match) begin
										nx.state = S_IDLE;
									end
								end
								S_WORD: begin
									nx.ptr   = rx_byte;
									nx.valid = '0;
									nx.after = S_WDATA;
								end
								default: begin
									// wraps within the page
									nx.page[st.ptr[2:0]]  = rx_byte;
									nx.valid[st.ptr[2:0]] = 1'b1;
									nx.ptr[2:0] = st.ptr[2:0] + 3'h1;
									nx.after    = S_WDATA;
								end
							endcase
						end
					end
				end
				S_ACK: begin
					// pull low at one fall; at the next, let go, or drive the first bit of a read
					if (scl_fall) begin
						if (!st.sda_oe) begin
							nx.sda_oe = 1'b1;
						end else begin
							nx.sda_oe = 1'b0;
							nx.cnt    = BIT_FIRST;
							nx.state  = st.after;
							if (st.after == S_RDATA) begin
								nx.tx     = mem_rd;
								nx.sda_oe = ~mem_rd[7];
							end
						end
					end
				end
				S_RDATA: begin
					// new bit only after clock falls
					if (scl_fall) begin
						if (st.cnt == BIT_LAST) begin
							nx.sda_oe = 1'b0;
							nx.ptr    = st.ptr + 8'h01;
							nx.state  = S_RACK;
						end else begin
							nx.cnt    = st.cnt + 3'h1;
							nx.tx     = {st.tx[6:0], 1'b0};
							nx.sda_oe = ~st.tx[6];
						end
					end
				end
				S_RACK: begin
					if (scl_rise && st.sda_s2) begin
						nx.state = S_IDLE;
					end else if (scl_fall) begin
						nx.tx     = mem_rd;
						nx.sda_oe = ~mem_rd[7];
						nx.cnt    = BIT_FIRST;
						nx.state  = S_RDATA;
					end
				end
				default: begin
					nx.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// ******************************************************
	// registers
	// ******************************************************
	// sync stages reset low; idle state ignores the edges this makes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= '0;
		end else if (ce_in) begin
			st <= nx;
		end
	end

	// open drain: the pad only ever pulls low
	assign sda_out    = 1'b0;
	assign sda_oe_out = st.sda_oe;
	assign busy_out   = st.busy;

	// ******************************************************
	// checks
	// ******************************************************
	a_no_ack_busy: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(st.state == S_ACK) |-> !st.busy)
		else $error("acknowledge phase while write cycle runs");

	a_start_addr: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && start_det) |=> (st.state == S_ADDR && st.cnt == 3'h0
			&& !st.sda_oe))
		else $error("start did not open address phase");

	a_stop_idle: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && stop_det) |=> (st.state == S_IDLE && !st.sda_oe))
		else $error("stop did not return to idle");

	a_mismatch_idle: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && st.state == S_ADDR && scl_rise && st.cnt == 3'h7
			&& !addr_match) |=> (st.state == S_IDLE && !st.sda_oe))
		else $error("unmatched address was not ignored");

	a_hold_high: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && st.scl_s2 && st.scl_p && !start_det && !stop_det)
			|=> $stable(st.sda_oe))
		else $error("data drive changed while clock high");

	a_stop_commit: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && stop_det && (|st.valid) && !st.busy)
			|=> (st.busy && st.commit && st.cidx == 3'h0))
		else $error("stop after data did not start write");

	a_page_wrap: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && st.state == S_WDATA && scl_rise && st.cnt == 3'h7)
			|=> (st.ptr[7:3] == $past(st.ptr[7:3])
			&& st.ptr[2:0] == 3'($past(st.ptr[2:0]) + 3'h1)))
		else $error("page pointer did not wrap in page");

	a_read_step: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && st.state == S_RDATA && scl_fall && st.cnt == 3'h7)
			|=> (st.ptr == 8'($past(st.ptr) + 8'h01)
			&& st.state == S_RACK && !st.sda_oe))
		else $error("read pointer did not advance by one");

	a_nack_release: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && st.state == S_RACK && scl_rise && st.sda_s2
			&& !stop_det) |=> (st.state == S_IDLE && !st.sda_oe))
		else $error("line not released after master nack");

	a_dir_select: assert property (
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && st.state == S_ADDR && scl_rise && st.cnt == 3'h7
			&& addr_match) |=> (st.is_read == $past(st.sda_s2)
			&& st.state == S_ACK))
		else $error("direction bit not taken");

endmodule // eeprom_slave

//--- include/eeprom_pkg.sv
package eeprom_pkg;

	// ******************************************************
	// array and page geometry
	// ******************************************************
	localparam int unsigned ARRAY_WORDS = 128;
	localparam int unsigned ADDR_W      = 7;
	localparam int unsigned PAGE_BYTES  = 8;
	localparam int unsigned PAGE_W      = 3;

	// ******************************************************
	// slave address field and bit counter limits
	// ******************************************************
	localparam logic [3:0] DEVICE_CODE = 4'hA;
	localparam logic [2:0] BIT_LAST    = 3'h7;
	localparam logic [2:0] BIT_FIRST   = 3'h0;

	// ******************************************************
	// self-timed write cycle
	// ******************************************************
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned TWR_TYP_MS    = 2;
	localparam int unsigned TWR_MAX_MS    = 10;
	localparam int unsigned TWR_CYCLES    = TWR_TYP_MS * (CLK_HZ / 1000);
	localparam int unsigned TWR_MAX_CYC   = TWR_MAX_MS * (CLK_HZ / 1000);
	localparam int unsigned TIMER_W       = 20;

	// ******************************************************
	// bus engine states
	// ******************************************************
	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_WORD,
		S_WDATA,
		S_ACK,
		S_RDATA,
		S_RACK
	} fsm_t;

endpackage

//--- verification/bus_master_model.sv
`timescale 1ns/1ps
// ****************************************
// two-wire master, drives at falling clk
// ****************************************
module bus_master_model (
	input  wire logic       clk_in,
	input  wire logic       sda_in,
	output logic            scl_out,
	output logic            sda_oe_out,
	output logic            got_valid_out,
	output logic [7:0]      got_out
);
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
		got_valid_out = 1'b0;
		got_out = 8'h00;
	end
	task automatic half();
		repeat (4) @(negedge clk_in);
	endtask
	task automatic report(input logic [7:0] v);
		got_out = v;
		got_valid_out = 1'b1;
		@(negedge clk_in);
		got_valid_out = 1'b0;
	endtask
	// also serves as repeated start: release data, then raise clock
	task automatic start_cond();
		sda_oe_out = 1'b0;
		half();
		scl_out = 1'b1;
		half();
		sda_oe_out = 1'b1;
		half();
		scl_out = 1'b0;
	endtask
	task automatic stop_cond();
		sda_oe_out = 1'b1;
		half();
		scl_out = 1'b1;
		half();
		sda_oe_out = 1'b0;
		half();
	endtask
	// data set only while clock is low, one pulse per bit
	task automatic bit_out(input logic b);
		sda_oe_out = ~b;
		half();
		scl_out = 1'b1;
		half();
		scl_out = 1'b0;
	endtask
	task automatic bit_in(output logic b);
		sda_oe_out = 1'b0;
		half();
		scl_out = 1'b1;
		repeat (2) @(negedge clk_in);
		b = sda_in;
		repeat (2) @(negedge clk_in);
		scl_out = 1'b0;
	endtask
	task automatic wr_byte(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--) bit_out(v[i]);
		bit_in(a);
		report({7'h00, ~a});
	endtask
	task automatic rd_byte(input logic last);
		logic [7:0] d;
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
		report(d);
		bit_out(last);
	endtask
endmodule // bus_master_model

//--- verification/tb_top.sv
`timescale 1ns/1ps
// ****************************************
// bench top
// ****************************************
module tb_top;
	import eeprom_pkg::*;
	localparam int unsigned WC = 200;
	logic clk, rst, ce, scl, m_oe, d_oe, d_sda, busy, got_valid;
	logic [2:0] straps;
	logic [7:0] got, ctl_w, ctl_r, base;
	logic [7:0] page [8];
	logic [7:0] dat [10];
	logic [31:0] rnd;
	logic [15:0] cnt, frz;
	logic [15:0] exp_q [$];
	int fail_count, comparisons;
	// open drain with pull-up: low when anyone pulls
	wire sda_line = ~m_oe & (~d_oe | d_sda);

	eeprom_slave #(.WRITE_CYCLES(WC)) i_dut (.clk_in(clk), .rst_in(rst),
		.ce_in(ce), .scl_in(scl), .sda_in(sda_line),
		.chip_select_straps_in(straps), .sda_out(d_sda),
		.sda_oe_out(d_oe), .busy_out(busy));
	bus_master_model i_master (.clk_in(clk), .sda_in(sda_line),
		.scl_out(scl), .sda_oe_out(m_oe), .got_valid_out(got_valid),
		.got_out(got));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic [7:0] v, input logic ack);
		exp_q.push_back({15'h0000, ack});
		i_master.wr_byte(v);
	endtask
	task automatic rb(input logic [7:0] v, input logic last);
		exp_q.push_back({8'h00, v});
		i_master.rd_byte(last);
	endtask
	task automatic tally_and_finish();
		if (exp_q.size() != 0) begin
			fail_count++;
			$display("unexpected pending results: expected 0 seen %0d",
				exp_q.size());
		end
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (got_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("unplanned result", {8'h00, got}, 16'hXXXX);
			end else begin
				check("bus result", {8'h00, got}, exp_q.pop_front());
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("unexpected watchdog: expected done seen timeout");
		tally_and_finish();
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		rnd = 32'hF00F;
		straps = rnd[2:0];
		fail_count = 0;
		comparisons = 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		// every strap code, then a wrong device code
		for (int k = 0; k < 9; k++) begin
			i_master.start_cond();
			ctl_w = {(k == 8) ? 4'h5 : DEVICE_CODE, k[2:0], 1'b0};
			wb(ctl_w, k < 8 && k[2:0] == straps);
			wb(8'h00, k < 8 && k[2:0] == straps);
			i_master.stop_cond();
		end
		$display("test address match done");
		ctl_w = {DEVICE_CODE, straps, 1'b0};
		ctl_r = {DEVICE_CODE, straps, 1'b1};
		rnd = lfsr(rnd);
		base = {1'b0, rnd[6:3], 3'h3};
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			dat[i] = rnd[7:0];
			page[(base[2:0] + i) % 8] = rnd[7:0];
		end
		i_master.start_cond();
		wb(ctl_w, 1'b1);
		wb(base, 1'b1);
		for (int i = 0; i < 10; i++) wb(dat[i], 1'b1);
		rnd = lfsr(rnd);
		frz = 16'(4 + rnd[3:0]);
		// counting starts before the stop so no busy cycle is missed
		fork
			begin
				cnt = 0;
				for (int i = 0; i < 1000 && !(cnt != 0 && busy !== 1'b1); i++) begin
					@(posedge clk);
					#1;
					if (busy === 1'b1) cnt++;
				end
			end
			begin
				i_master.stop_cond();
				i_master.start_cond();
				wb(ctl_w, 1'b0);
				i_master.stop_cond();
			end
			begin
				// freeze mid write cycle: busy must stretch by the same count
				repeat (150) @(negedge clk);
				ce = 1'b0;
				repeat (frz) @(negedge clk);
				ce = 1'b1;
			end
		join
		check("busy length", cnt, 16'(8 + WC + frz));
		$display("test page write done");
		i_master.start_cond();
		wb(ctl_w, 1'b1);
		wb({1'b0, base[6:3], 3'h0}, 1'b1);
		i_master.start_cond();
		wb(ctl_r, 1'b1);
		for (int i = 0; i < 7; i++) rb(page[i], i == 6);
		i_master.stop_cond();
		i_master.start_cond();
		wb(ctl_r, 1'b1);
		rb(page[7], 1'b1);
		i_master.stop_cond();
		repeat (4) @(negedge clk);
		$display("test reads done");
		tally_and_finish();
	end
endmodule // tb_top
